//--- tsf_pkg.sv
`default_nettype none
package tsf_pkg;
	localparam int HDR_MAX_BYTES = 254;
	localparam int DATA_W = 64;
	localparam int BYTES_W = 8;
	localparam logic [15:0] MSS_DEFAULT = 16'h05B4;
	localparam logic [15:0] PSH_BIT = 16'h0008;
	localparam logic [7:0] HDR_LIMIT = 8'hFE;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY = 32'h82F6_3B78;
	localparam int CTX_DEPTH = 16;
	localparam int CTX_AW = 4;

	typedef enum logic [1:0]
	{
		TSF_MODE_RAW = 2'b00,
		TSF_MODE_TCP = 2'b01,
		TSF_MODE_ULP = 2'b10,
		TSF_MODE_DDP = 2'b11
	} tsf_mode_t;

	typedef struct packed
	{
		logic [CTX_AW-1:0] conn;
		tsf_mode_t mode;
		logic ipv6;
		logic ipv6_ext;
		logic udp;
		logic crc_en;
		logic crc_last;
		logic [63:0] host_addr;
		logic [31:0] length;
		logic [15:0] mss;
		logic [7:0] hdr_len;
		logic [31:0] ulp_offset;
	} tsf_cmd_t;

	typedef struct packed
	{
		logic [63:0] addr;
		logic [15:0] len;
	} tsf_rd_req_t;

	typedef struct packed
	{
		logic [15:0] seg_len;
		logic push;
		logic csum_en;
		logic [7:0] hdr_len;
		logic [31:0] ulp_offset;
		logic [31:0] crc;
		logic crc_valid;
		logic bypass;
		logic [15:0] csum;
	} tsf_seg_t;

	typedef enum logic [2:0]
	{
		TSF_IDLE = 3'b000,
		TSF_HDR = 3'b001,
		TSF_REQ = 3'b010,
		TSF_DATA = 3'b011,
		TSF_TRAIL = 3'b100
	} tsf_state_t;
endpackage
`default_nettype wire

//--- tsf_sum.sv
`timescale 1ns/100ps
`default_nettype none
// Running ones-complement sum and CRC over one payload word per cycle
module tsf_sum
	import tsf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic [31:0] crc_seed,
	input wire logic step,
	input wire logic [DATA_W-1:0] word,
	// Results
	output logic [15:0] csum,
	output logic [31:0] crc
);
	logic [16:0] acc;
	logic [16:0] next_acc;
	logic [31:0] next_crc;

	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [DATA_W-1:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < DATA_W; i++)
		begin
			r = ((r[0] ^ d[i]) ? CRC_POLY : 32'h0000_0000) ^ {1'b0, r[31:1]};
		end
		return r;
	endfunction

	always_comb
	begin
		logic [18:0] s;
		s = {2'b00, acc} + {3'b000, word[15:0]} + {3'b000, word[31:16]}
			+ {3'b000, word[47:32]} + {3'b000, word[63:48]};
		next_acc = acc;
		next_crc = crc;
		if (clear)
		begin
			next_acc = 17'h0_0000;
			next_crc = crc_seed;
		end
		else if (step)
		begin
			// Fold carries on every step so the accumulator never overflows
			next_acc = {1'b0, s[15:0]} + {14'h0000, s[18:16]};
			next_crc = crc_word(crc, word);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			acc <= 17'h0_0000;
			crc <= CRC_INIT;
		end
		else
		begin
			acc <= next_acc;
			crc <= next_crc;
		end
	end

	assign csum = ~(acc[15:0] + {15'h0000, acc[16]});
endmodule
`default_nettype wire

//--- tsf_framer.sv
// Summary of operation
// - Cut fetched payload into segments, add headers, CRC, then send out.
// - Fetch payload by host read requests at the command's buffer address.
// - Per-connection context only carries partial CRC between message pieces.
// - Insert TCP/UDP checksum when header length is up to 254 bytes.
// - Segment large TCP packets only when header length is at most 254 bytes.
// - Segment IPv6 only when the header has no extension options.
// - Push flag set on last segment of a PDU only.
// - One command yields all segments in automatic segmentation mode.
// - DDP slices repeat ULP header with offset advanced by payload sent.
`timescale 1ns/100ps
`default_nettype none
module tsf_framer
	import tsf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Command from the transmit processor
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire tsf_cmd_t cmd,
	// Host read requests
	output logic rd_valid,
	input wire logic rd_ready,
	output tsf_rd_req_t rd_req,
	// Host read data
	input wire logic rd_data_valid,
	output logic rd_data_ready,
	input wire logic [DATA_W-1:0] rd_data,
	// Segment descriptor toward the MAC path
	output logic seg_valid,
	input wire logic seg_ready,
	output tsf_seg_t seg,
	// Payload toward the MAC path
	output logic pay_valid,
	input wire logic pay_ready,
	output logic [DATA_W-1:0] pay_data,
	output logic pay_last
);
	tsf_state_t state;
	tsf_state_t next_state;
	tsf_cmd_t cur;
	tsf_cmd_t next_cur;
	logic [31:0] remain;
	logic [31:0] next_remain;
	logic [31:0] sent;
	logic [31:0] next_sent;
	logic [15:0] seg_left;
	logic [15:0] next_seg_left;
	logic [15:0] cur_seg;
	logic [15:0] next_cur_seg;
	logic [63:0] addr;
	logic [63:0] next_addr;
	logic [31:0] crc_ctx [CTX_DEPTH];
	logic seg_ok;
	logic csum_ok;
	logic sum_clear;
	logic sum_step;
	logic [15:0] csum;
	logic [31:0] crc_run;
	logic [31:0] crc_seed;
	logic [DATA_W-1:0] pay_q;
	logic pay_v;
	logic last_q;
	logic [DATA_W-1:0] next_pay_q;
	logic next_pay_v;
	logic next_last_q;
	logic word_take;
	logic seg_done;

	// Headers over the limit, or IPv6 with options, go out as one unsegmented packet
	assign csum_ok = (cur.hdr_len <= HDR_LIMIT);
	assign seg_ok = csum_ok && !(cur.ipv6 && cur.ipv6_ext)
		&& (cur.mode != TSF_MODE_RAW);
	assign cmd_ready = (state == TSF_IDLE);
	assign rd_valid = (state == TSF_REQ);
	assign rd_req.addr = addr;
	assign rd_req.len = cur_seg;
	assign word_take = rd_data_valid && rd_data_ready;
	assign rd_data_ready = (state == TSF_DATA) && (!pay_v || pay_ready);
	assign sum_clear = (state == TSF_HDR);
	assign sum_step = word_take;
	// First segment resumes the stored partial CRC; later segments run on unbroken
	assign crc_seed = (sent == 32'h0000_0000) ? crc_ctx[cur.conn] : crc_run;
	assign seg_done = word_take && (seg_left <= BYTES_W[15:0]);
	assign pay_valid = pay_v;
	assign pay_data = pay_q;
	assign pay_last = last_q;
	assign seg_valid = (state == TSF_TRAIL);

	tsf_sum u_sum
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(sum_clear),
		.crc_seed(crc_seed),
		.step(sum_step),
		.word(rd_data),
		.csum(csum),
		.crc(crc_run)
	);

	always_comb
	begin
		logic [31:0] seg_sz;
		seg_sz = seg_ok ? {16'h0000, cur.mss} : cur.length;
		next_state = state;
		next_cur = cur;
		next_remain = remain;
		next_sent = sent;
		next_seg_left = seg_left;
		next_cur_seg = cur_seg;
		next_addr = addr;
		case (state)
			TSF_IDLE:
			begin
				if (cmd_valid)
				begin
					next_cur = cmd;
					if (cmd.mss == ZERO16)
					begin
						next_cur.mss = MSS_DEFAULT;
					end
					next_remain = cmd.length;
					next_sent = 32'h0000_0000;
					next_addr = cmd.host_addr;
					next_state = TSF_HDR;
				end
			end
			TSF_HDR:
			begin
				// Segment size is the smaller of what remains and the segment limit
				if (remain > seg_sz)
				begin
					next_cur_seg = seg_sz[15:0];
				end
				else
				begin
					next_cur_seg = remain[15:0];
				end
				next_seg_left = next_cur_seg;
				next_state = TSF_REQ;
			end
			TSF_REQ:
			begin
				if (rd_ready)
				begin
					next_state = TSF_DATA;
				end
			end
			TSF_DATA:
			begin
				if (word_take)
				begin
					next_seg_left = seg_left - BYTES_W[15:0];
				end
				if (seg_done)
				begin
					next_state = TSF_TRAIL;
				end
			end
			TSF_TRAIL:
			begin
				if (seg_ready)
				begin
					next_remain = remain - {16'h0000, cur_seg};
					next_sent = sent + {16'h0000, cur_seg};
					next_addr = addr + {48'h0000_0000_0000, cur_seg};
					// One command runs every segment without a new command
					next_state = (remain <= {16'h0000, cur_seg}) ? TSF_IDLE : TSF_HDR;
				end
			end
			default:
			begin
				next_state = TSF_IDLE;
			end
		endcase
	end

	always_comb
	begin
		logic last_seg;
		last_seg = (remain <= {16'h0000, cur_seg});
		seg = '0;
		seg.seg_len = cur_seg;
		seg.push = last_seg;
		seg.csum_en = csum_ok;
		seg.hdr_len = cur.hdr_len;
		seg.bypass = !seg_ok;
		seg.ulp_offset = (cur.mode == TSF_MODE_DDP) ? cur.ulp_offset + sent : cur.ulp_offset;
		seg.crc = ~crc_run;
		seg.crc_valid = cur.crc_en && last_seg && cur.crc_last;
		seg.csum = csum;
		next_pay_q = pay_q;
		next_pay_v = pay_v;
		next_last_q = last_q;
		if (pay_v && pay_ready)
		begin
			next_pay_v = 1'b0;
		end
		if (word_take)
		begin
			next_pay_q = rd_data;
			next_pay_v = 1'b1;
			next_last_q = seg_done;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state <= TSF_IDLE;
			cur <= '0;
			remain <= 32'h0000_0000;
			sent <= 32'h0000_0000;
			seg_left <= 16'h0000;
			cur_seg <= 16'h0000;
			addr <= 64'h0000_0000_0000_0000;
			pay_q <= 64'h0000_0000_0000_0000;
			pay_v <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			remain <= next_remain;
			sent <= next_sent;
			seg_left <= next_seg_left;
			cur_seg <= next_cur_seg;
			addr <= next_addr;
			pay_q <= next_pay_q;
			pay_v <= next_pay_v;
			last_q <= next_last_q;
		end
	end

	// CRC context: saved at message end unless the message is final
	generate
		for (genvar i = 0; i < CTX_DEPTH; i++)
		begin : g_ctx
			always_ff @(posedge ref_clk)
			begin
				if (rst)
				begin
					crc_ctx[i] <= CRC_INIT;
				end
				else if (state == TSF_TRAIL && seg_ready && cur.conn == CTX_AW'(i)
					&& remain <= {16'h0000, cur_seg})
				begin
					crc_ctx[i] <= cur.crc_last ? CRC_INIT : crc_run;
				end
			end
		end
	endgenerate

	sequence s_cmd_take;
		cmd_valid && cmd_ready;
	endsequence

	a_cmd_take: assert property (@(posedge ref_clk) disable iff (rst)
		s_cmd_take |=> state == TSF_HDR && cur.host_addr == $past(cmd.host_addr))
		else $error("command not taken");
	a_ready_idle: assert property (@(posedge ref_clk) disable iff (rst)
		cmd_ready |-> state == TSF_IDLE) else $error("ready outside idle");
	a_push_last: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && seg.push |-> remain <= {16'h0000, seg.seg_len})
		else $error("push on non-final segment");
	a_seg_bound: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && !seg.bypass |-> seg.seg_len <= cur.mss) else $error("segment over mss");
	a_ipv6_ext: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && cur.ipv6 && cur.ipv6_ext |-> seg.bypass) else $error("ipv6 options cut");
	a_csum_lim: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && seg.csum_en |-> seg.hdr_len <= HDR_LIMIT) else $error("checksum over limit");
	a_req_addr: assert property (@(posedge ref_clk) disable iff (rst)
		rd_valid && sent == 32'h0000_0000 |-> rd_req.addr == cur.host_addr)
		else $error("wrong fetch address");
	a_ddp_offs: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && cur.mode == TSF_MODE_DDP |-> seg.ulp_offset == cur.ulp_offset + sent)
		else $error("ddp offset wrong");
	a_multi_seg: assert property (@(posedge ref_clk) disable iff (rst)
		seg_valid && seg_ready && !seg.push |=> state == TSF_HDR ##1 rd_valid)
		else $error("next segment not started");
	a_hdr_req: assert property (@(posedge ref_clk) disable iff (rst)
		state == TSF_HDR |=> rd_valid) else $error("fetch not issued");
	a_crc_seed: assert property (@(posedge ref_clk) disable iff (rst)
		state == TSF_IDLE && cmd_valid |=> ##2 crc_run == crc_ctx[cur.conn])
		else $error("crc not resumed");
endmodule
`default_nettype wire

//--- tsf_host_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Host memory behind PCIe reads; each word carries its own byte address
module tsf_host_mem
	import tsf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pacing
	input wire logic slow,
	// Read requests
	input wire logic rd_valid,
	output logic rd_ready,
	input wire tsf_rd_req_t rd_req,
	// Read data
	output logic rd_data_valid,
	input wire logic rd_data_ready,
	output logic [DATA_W-1:0] rd_data
);
	logic [63:0] addr;
	logic [15:0] words;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			words <= 16'h0000;
			rd_ready <= 1'b0;
			rd_data_valid <= 1'b0;
			rd_data <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			// One request in flight; a new one waits until its words are gone
			rd_ready <= rd_valid && !rd_ready && words == 16'h0000 && !rd_data_valid && !slow;
			if (rd_valid && rd_ready)
			begin
				addr <= rd_req.addr;
				words <= (rd_req.len + 16'h0007) >> 3;
			end
			else if ((!rd_data_valid || rd_data_ready) && words != 16'h0000 && !slow)
			begin
				rd_data_valid <= 1'b1;
				rd_data <= {addr[31:0], addr[31:0] ^ 32'h5A5A_C3C3};
				addr <= addr + 64'h0000_0000_0000_0008;
				words <= words - 16'h0001;
			end
			else if (rd_data_valid && rd_data_ready)
				rd_data_valid <= 1'b0;
			else if (!rd_data_valid)
				rd_data <= ~rd_data; // Idle bus shows noise, not stale data
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
	import tsf_pkg::*;
;
	logic ref_clk, rst, cmd_valid, cmd_ready, rd_valid, rd_ready, rd_data_valid;
	logic rd_data_ready, seg_valid, seg_ready, pay_valid, pay_ready, pay_last, slow;
	tsf_cmd_t cmd;
	tsf_rd_req_t rd_req;
	tsf_seg_t seg;
	logic [DATA_W-1:0] rd_data, pay_data;
	logic [108:0] seg_q[$];
	logic [64:0] pay_q[$];
	logic [108:0] se;
	logic [64:0] pe;
	logic [31:0] ctx_m [CTX_DEPTH];
	int err_count, num_checks, cycles;

	tsf_framer tsf_framer_i (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd, .rd_valid,
		.rd_ready, .rd_req, .rd_data_valid, .rd_data_ready, .rd_data, .seg_valid,
		.seg_ready, .seg, .pay_valid, .pay_ready, .pay_data, .pay_last);
	tsf_host_mem tsf_host_mem_i (.ref_clk, .rst, .slow, .rd_valid, .rd_ready, .rd_req,
		.rd_data_valid, .rd_data_ready, .rd_data);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok)
		begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// Reflected CRC over one 64-bit word, low bit first
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [63:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 64; i++)
			r = ((r[0] ^ d[i]) ? CRC_POLY : 32'h0000_0000) ^ (r >> 1);
		return r;
	endfunction

	// Notes the expected segments and words, then offers the command
	task send(input tsf_mode_t m, input logic [31:0] len, input logic [15:0] mss,
		input logic [7:0] hdr, input logic v6, input logic ext, input logic [31:0] off);
		logic [31:0] eff, o, l, k, c, s;
		logic [63:0] a, w;
		logic byp, ce;
		a = {32'h0000_0000, $urandom & 32'hFFFF_FFF8};
		eff = (mss == 16'h0000) ? MSS_DEFAULT : mss;
		byp = hdr > HDR_MAX_BYTES || m == TSF_MODE_RAW || (v6 && ext);
		ce = hdr <= HDR_MAX_BYTES;
		c = ctx_m[a[6:3]];
		if (byp)
			eff = len;
		for (o = 0; o < len; o += eff)
		begin
			l = (len - o < eff) ? len - o : eff;
			s = 32'h0000_0000;
			for (k = 0; k < l; k += 8)
			begin
				w = {a[31:0] + o + k, (a[31:0] + o + k) ^ 32'h5A5A_C3C3};
				c = crc_step(c, w);
				s += w[15:0] + w[31:16] + w[47:32] + w[63:48];
				pay_q.push_back({k + 8 >= l, w});
			end
			s = s[15:0] + s[31:16];
			s = s[15:0] + s[31:16];
			seg_q.push_back({~s[15:0], hdr, ~c, o + l == len && a[8], ce,
				m == TSF_MODE_DDP, byp, o + l == len, off + o, l[15:0]});
		end
		// A final message restarts its connection's CRC; an unfinished one carries on
		ctx_m[a[6:3]] = a[8] ? CRC_INIT : c;
		@(negedge ref_clk);
		cmd <= {a[6:3], m, v6, ext, a[7], 1'b1, a[8], a, len, mss, hdr, off};
		cmd_valid <= 1'b1;
		// Held while busy; taken once the framer is idle
		do
			@(posedge ref_clk);
		while (cmd_ready !== 1'b1);
		@(negedge ref_clk);
		cmd_valid <= 1'b0;
	endtask

	always @(negedge ref_clk)
	begin
		seg_ready <= $urandom % 4 != 0;
		pay_ready <= $urandom % 4 != 0;
		slow <= $urandom % 3 == 0;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			err_count++;
			$display("BAD %0t timeout", $time);
			tally_and_finish;
		end
	end

	always @(posedge ref_clk)
	begin
		if (!rst && seg_valid && seg_ready)
		begin
			se = seg_q.size() ? seg_q.pop_front() : 109'h0;
			chk(seg.seg_len === se[15:0] && seg.bypass === se[49], "size");
			chk(seg.push === se[48], "push flag");
			chk(!se[50] || seg.ulp_offset === se[47:16], "ddp offset");
			chk(seg.csum_en === se[51] && seg.hdr_len === se[92:85], "checksum enable");
			chk(!se[51] || seg.csum === se[108:93], "checksum");
			chk(seg.crc_valid === se[52] && (!se[52] || seg.crc === se[84:53]), "crc");
		end
		if (!rst && pay_valid && pay_ready)
		begin
			pe = pay_q.size() ? pay_q.pop_front() : 65'h0;
			chk({pay_last, pay_data} === pe, "payload");
		end
	end

	initial
	begin
		void'($urandom(32'hee7fb851));
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		seg_ready = 1'b0;
		pay_ready = 1'b0;
		slow = 1'b0;
		err_count = 0;
		num_checks = 0;
		cycles = 0;
		foreach (ctx_m[i])
			ctx_m[i] = CRC_INIT;
		repeat (5) @(negedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk(cmd_ready === 1'b1 && rd_valid === 1'b0 && seg_valid === 1'b0, "idle");
		send(TSF_MODE_TCP, 3000, 1000, 54, 0, 0, 0);
		send(TSF_MODE_TCP, 2500, 0, 54, 0, 0, 0);
		send(TSF_MODE_TCP, 20, 8, 254, 0, 0, 0);
		send(TSF_MODE_TCP, 20, 8, 255, 0, 0, 0);
		send(TSF_MODE_TCP, 30, 8, 74, 1, 0, 0);
		send(TSF_MODE_TCP, 30, 8, 74, 1, 1, 0);
		send(TSF_MODE_DDP, 24, 8, 60, 0, 0, 32'd100);
		send(TSF_MODE_ULP, 17, 8, 60, 0, 0, 0);
		send(TSF_MODE_RAW, 40, 8, 60, 0, 0, 0);
		repeat (6) send(TSF_MODE_TCP, 1 + $urandom % 300, 16'(8 + 8 * ($urandom % 16)),
			8'($urandom), 0, 0, 0);
		wait (seg_q.size() == 0 && pay_q.size() == 0);
		repeat (20) @(posedge ref_clk);
		tally_and_finish;
	end
endmodule
`default_nettype wire
